// *** frame_check.sv ***
`include "frame_defs.svh"

module char_fifo
	#(
		parameter int WIDTH = 8,
		parameter int DEPTH = 32
	)
	(
		// clock and reset
		input  wire logic             clk,
		input  wire logic             rstn,
		// fill side
		input  wire logic [WIDTH-1:0] in_data,
		input  wire logic             in_valid,
		output logic                  in_ready,
		// drain side
		output logic      [WIDTH-1:0] out_data,
		output logic                  out_valid,
		input  wire logic             out_ready
	);

	// depth must be a power of two for the pointer wrap
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;

	wire full = (wr_ptr_reg ^ rd_ptr_reg) == {1'b1, {AW{1'b0}}};
	wire push = in_valid & ~full;
	wire pop  = out_valid & out_ready;

	assign in_ready  = ~full;
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
			rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
		end
	end

endmodule : char_fifo

module frame_check
	import frame_pkg::*;
	#(
		parameter int GAP_CYCLES = `GAP_MS * `CLK_KHZ
	)
	(
		// clock and reset
		input  wire logic        clk,
		input  wire logic        rstn,
		// configuration
		input  wire logic        ascii_mode,
		input  wire logic [7:0]  station_addr,
		// received characters
		input  wire logic [7:0]  rx_data,
		input  wire logic        rx_valid,
		output logic             rx_ready,
		// transmitted characters
		output logic [7:0]       tx_data,
		output logic             tx_valid,
		input  wire logic        tx_ready,
		// register writes
		output logic             wr_valid,
		output logic [15:0]      wr_addr,
		output logic [15:0]      wr_data,
		// frame results
		output logic             frame_ok,
		output logic             frame_err
	);

	localparam int GW = $clog2(GAP_CYCLES + 1);

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n > `NIB_DIG_MAX) ? {4'h0, n} + `CH_UP_OFS
			: {4'h0, n} + `CH_DIG_OFS;
	endfunction : hex_char

	state_type   state_reg;
	state_type   state_next;
	logic [7:0]  mem_reg [`MEM_WORDS];
	logic [4:0]  cnt_reg;
	logic [GW-1:0] gap_reg;
	logic [15:0] crc_reg;
	logic [3:0]  crc_cnt_reg;
	logic [7:0]  lrc_reg;
	logic        in_frame_reg;
	logic        half_reg;
	logic        cr_reg;
	logic        bad_reg;
	logic [3:0]  hi_nib_reg;
	logic [3:0]  wk_reg;
	logic [4:0]  tx_cnt_reg;
	logic        rx_ready_reg;
	logic [7:0]  tx_data_reg;
	logic        tx_valid_reg;
	logic        wr_valid_reg;
	logic [15:0] wr_addr_reg;
	logic [15:0] wr_data_reg;
	logic        frame_ok_reg;
	logic        frame_err_reg;
	logic        fifo_in_ready;
	logic [7:0]  fifo_out_data;
	logic        fifo_out_valid;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// receive decode
	wire rx_take  = rx_valid & rx_ready_reg;
	wire is_dig   = rx_data >= `CH_DIG_LO && rx_data <= `CH_DIG_HI;
	wire is_up    = rx_data >= `CH_UP_LO && rx_data <= `CH_UP_HI;
	wire [3:0] rx_nib = is_up ? rx_data[3:0] + `NIB_UP_ADJ : rx_data[3:0];
	wire asc_take  = rx_take & ascii_mode;
	wire asc_start = asc_take & rx_data == `CH_COLON;
	wire asc_in    = asc_take & in_frame_reg & ~asc_start;
	wire asc_hex   = asc_in & ~cr_reg & (is_dig | is_up);
	wire asc_cr    = asc_in & ~cr_reg & rx_data == `CH_CR;
	wire asc_end   = asc_in & cr_reg & rx_data == `CH_LF;
	wire asc_other = asc_in & ~asc_hex & ~asc_cr & ~asc_end;
	wire asc_store = asc_hex & half_reg;
	wire rtu_store = rx_take & ~ascii_mode;
	wire store     = asc_store | rtu_store;
	wire [7:0] store_byte = ascii_mode ? {hi_nib_reg, rx_nib} : rx_data;
	wire gap_full  = gap_reg == GW'(GAP_CYCLES);
	wire rtu_end   = ~ascii_mode & cnt_reg != 5'h00 & gap_full
		& crc_cnt_reg == 4'h0;
	wire frame_end = asc_end | rtu_end;

	// frame acceptance
	wire [7:0] cnt8    = {3'b000, cnt_reg};
	wire [7:0] chk_len = ascii_mode ? `ASC_CHK_LEN : `RTU_CHK_LEN;
	wire [7:0] wc      = mem_reg[`IDX_WC_LO];
	wire [7:0] bc      = mem_reg[`IDX_BC];
	wire [7:0] func    = mem_reg[`IDX_FUNC];
	wire bcast    = mem_reg[`IDX_ADDR] == `BCAST_ADDR;
	wire hit      = bcast | mem_reg[`IDX_ADDR] == station_addr;
	wire write_ok = func == `FN_WRITE && mem_reg[`IDX_WC_HI] == 8'h00
		&& wc != 8'h00 && wc <= `MAX_WORDS && bc == {wc[6:0], 1'b0}
		&& cnt8 == `HDR_LEN8 + bc + chk_len;
	wire loop_ok  = func == `FN_LOOP && cnt8 == `LOOP_LEN8 + chk_len;
	wire sum_ok   = ascii_mode
		? lrc_reg == `LRC_CLEAR && ~half_reg && cnt_reg >= `ASC_MIN
		: crc_reg == 16'h0000 && cnt_reg >= `RTU_MIN;
	wire check_ok = ~bad_reg & sum_ok;
	wire accept   = frame_end & check_ok & hit & (write_ok | loop_ok);

	// reply stream
	wire push      = state_reg == ST_TX & fifo_in_ready
		& crc_cnt_reg == 4'h0;
	wire [4:0] tx_m1 = tx_cnt_reg - 5'h01;
	wire asc_nhi   = ~tx_m1[0];
	wire [7:0] tx_src = ascii_mode ? mem_reg[{2'b00, tx_m1[3:1]}]
		: mem_reg[{2'b00, tx_cnt_reg[2:0]}];
	wire [7:0] lrc_neg = ~lrc_reg + `LRC_ONE;
	wire [7:0] asc_byte = tx_cnt_reg >= `ASC_LRC_HI ? lrc_neg : tx_src;
	wire [3:0] asc_nib  = asc_nhi ? asc_byte[7:4] : asc_byte[3:0];
	wire [7:0] asc_char = tx_cnt_reg == 5'h00 ? `CH_COLON
		: tx_cnt_reg < `ASC_CR ? hex_char(asc_nib)
		: tx_cnt_reg == `ASC_CR ? `CH_CR : `CH_LF;
	wire [7:0] rtu_char = tx_cnt_reg == `RTU_CRC_LO ? crc_reg[7:0]
		: tx_cnt_reg == `RTU_LAST ? crc_reg[15:8] : tx_src;
	wire [7:0] tx_char = ascii_mode ? asc_char : rtu_char;
	wire [4:0] tx_last = ascii_mode ? `ASC_LAST : `RTU_LAST;
	wire tx_lrc_add = push & ascii_mode & tx_cnt_reg != 5'h00
		& tx_cnt_reg <= `ASC_BODY_LAST & asc_nhi;
	wire tx_crc_load = push & ~ascii_mode & tx_cnt_reg < `RTU_CRC_LO;

	// shared cyclic engine, one shift per clock
	wire crc_load   = rtu_store | tx_crc_load;
	wire crc_preset = rtu_store ? cnt_reg == 5'h00 : tx_cnt_reg == 5'h00;
	wire [7:0]  crc_din  = rtu_store ? rx_data : tx_src;
	wire [15:0] crc_base = crc_preset ? `CRC_PRESET : crc_reg;
	wire [15:0] crc_shift = {1'b0, crc_reg[15:1]}
		^ ({16{crc_reg[0]}} & `CRC_POLY);
	wire [3:0] crc_cnt_next = crc_load ? `CRC_STEPS
		: crc_cnt_reg != 4'h0 ? crc_cnt_reg - 4'h1 : 4'h0;

	// write phase
	wire wr_last = wk_reg == wc[3:0] - 4'h1;
	wire [4:0] wd_idx = `IDX_DATA + {wk_reg, 1'b0};

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RX:
				if (accept)
					state_next = write_ok ? ST_WRITE
						: bcast ? ST_RX : ST_TX;
			ST_WRITE:
				if (wr_last)
					state_next = bcast ? ST_RX : ST_TX;
			ST_TX:
				if (push && tx_cnt_reg == tx_last)
					state_next = ST_RX;
			default:
				state_next = ST_RX;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg    <= ST_RX;
			rx_ready_reg <= 1'b0;
			wk_reg       <= 4'h0;
			tx_cnt_reg   <= 5'h00;
		end
		else
		begin
			state_reg    <= state_next;
			// input held off while the engine shifts or a reply runs
			rx_ready_reg <= state_next == ST_RX && crc_cnt_next == 4'h0;
			wk_reg       <= state_reg == ST_WRITE ? wk_reg + 4'h1 : 4'h0;
			tx_cnt_reg   <= state_reg != ST_TX ? 5'h00
				: tx_cnt_reg + 5'(push);
		end
	end

	always_ff @(posedge clk)
	begin
		if (store)
			mem_reg[cnt_reg] <= store_byte;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_reg <= 5'h00;
			gap_reg <= '0;
			bad_reg <= 1'b0;
		end
		else
		begin
			if (frame_end | asc_start)
				cnt_reg <= 5'h00;
			else if (store && cnt_reg != `MEM_LAST)
				cnt_reg <= cnt_reg + 5'h01;
			// silence timer frames rtu messages
			if (rx_take)
				gap_reg <= '0;
			else if (!gap_full)
				gap_reg <= gap_reg + GW'(1);
			if (frame_end | asc_start)
				bad_reg <= 1'b0;
			else if (asc_other | (store & cnt_reg == `MEM_LAST))
				bad_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			in_frame_reg <= 1'b0;
			half_reg     <= 1'b0;
			cr_reg       <= 1'b0;
			hi_nib_reg   <= 4'h0;
		end
		else
		begin
			if (asc_start | asc_end)
				in_frame_reg <= asc_start;
			if (asc_start)
				half_reg <= 1'b0;
			else if (asc_hex)
				half_reg <= ~half_reg;
			if (asc_start | asc_end)
				cr_reg <= 1'b0;
			else if (asc_cr)
				cr_reg <= 1'b1;
			if (asc_hex & ~half_reg)
				hi_nib_reg <= rx_nib;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			lrc_reg <= `LRC_CLEAR;
		else if (frame_end | asc_start)
			lrc_reg <= `LRC_CLEAR;
		else if (asc_store)
			lrc_reg <= lrc_reg + store_byte;
		else if (tx_lrc_add)
			lrc_reg <= lrc_reg + tx_src;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			crc_reg     <= `CRC_PRESET;
			crc_cnt_reg <= 4'h0;
		end
		else
		begin
			crc_cnt_reg <= crc_cnt_next;
			if (crc_load)
				crc_reg <= crc_base ^ {8'h00, crc_din};
			else if (crc_cnt_reg != 4'h0)
				crc_reg <= crc_shift;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_valid_reg  <= 1'b0;
			wr_addr_reg   <= 16'h0000;
			wr_data_reg   <= 16'h0000;
			frame_ok_reg  <= 1'b0;
			frame_err_reg <= 1'b0;
		end
		else
		begin
			wr_valid_reg  <= state_reg == ST_WRITE;
			wr_addr_reg   <= {mem_reg[`IDX_START_HI], mem_reg[`IDX_START_LO]}
				+ {12'h000, wk_reg};
			wr_data_reg   <= {mem_reg[wd_idx], mem_reg[wd_idx + 5'h01]};
			frame_ok_reg  <= accept;
			frame_err_reg <= frame_end & ~check_ok;
		end
	end

	// output stage keeps the port a plain flop
	wire fifo_out_ready = ~tx_valid_reg | tx_ready;

	char_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) reply_fifo
	(
		.clk       (clk),
		.rstn      (rstn),
		.in_data   (tx_char),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready)
	);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_valid_reg <= 1'b0;
			tx_data_reg  <= 8'h00;
		end
		else if (fifo_out_ready)
		begin
			tx_valid_reg <= fifo_out_valid;
			tx_data_reg  <= fifo_out_data;
		end
	end

	assign rx_ready  = rx_ready_reg;
	assign tx_data   = tx_data_reg;
	assign tx_valid  = tx_valid_reg;
	assign wr_valid  = wr_valid_reg;
	assign wr_addr   = wr_addr_reg;
	assign wr_data   = wr_data_reg;
	assign frame_ok  = frame_ok_reg;
	assign frame_err = frame_err_reg;

	a_lrc_sum_zero: assert property (
		frame_ok_reg && ascii_mode |-> $past(lrc_reg) == `LRC_CLEAR)
		else $error("accepted ascii frame with nonzero sum");
	a_lrc_neg_sent: assert property (
		push && ascii_mode && tx_cnt_reg == `ASC_LRC_HI
		|-> tx_char == hex_char(lrc_neg[7:4]))
		else $error("ascii check high char wrong");
	a_crc_preset: assert property (
		crc_load && crc_preset |=> crc_reg[15:8] == 8'hFF)
		else $error("cyclic accumulator not preset");
	a_crc_merge: assert property (
		crc_load && !crc_preset |=> crc_reg
		== ($past(crc_reg) ^ {8'h00, $past(crc_din)}))
		else $error("byte not merged into low half");
	a_crc_shift_step: assert property (
		$past(crc_cnt_reg) != 4'h0
		|-> crc_reg == ({1'b0, $past(crc_reg[15:1])}
		^ ({16{$past(crc_reg[0])}} & `CRC_POLY)))
		else $error("shift step wrong");
	a_crc_eight_shifts: assert property (
		crc_load |=> (crc_cnt_reg != 4'h0)[*8] ##1 crc_cnt_reg == 4'h0)
		else $error("byte did not get eight shifts");
	a_crc_low_first: assert property (
		push && !ascii_mode && tx_cnt_reg == `RTU_CRC_LO
		|-> tx_char == crc_reg[7:0] ##1 crc_reg[15:8] == $past(crc_reg[15:8]))
		else $error("cyclic check order wrong");
	a_write_addr_step: assert property (
		wr_valid_reg && $past(wr_valid_reg)
		|-> wr_addr_reg == $past(wr_addr_reg) + 16'h0001)
		else $error("write addresses not consecutive");
	a_reply_echo: assert property (
		push && !ascii_mode && tx_cnt_reg < `RTU_CRC_LO
		|-> tx_char == mem_reg[{2'b00, tx_cnt_reg[2:0]}])
		else $error("reply header not echoed");
	a_ascii_hex_upper: assert property (
		push && ascii_mode && tx_cnt_reg != 5'h00 && tx_cnt_reg < `ASC_CR
		|-> (tx_char >= `CH_DIG_LO && tx_char <= `CH_DIG_HI)
		|| (tx_char >= `CH_UP_LO && tx_char <= `CH_UP_HI))
		else $error("ascii reply char not uppercase hex");
	a_rtu_gap_end: assert property (
		rtu_end |=> cnt_reg == 5'h00 && gap_reg == $past(gap_reg))
		else $error("rtu frame not closed by silence");
	a_no_bcast_reply: assert property (
		state_reg == ST_TX |-> !bcast)
		else $error("reply sent to broadcast");
	a_ascii_framing: assert property (
		push && ascii_mode && tx_cnt_reg == `ASC_CR
		|=> tx_cnt_reg == `ASC_LAST && tx_char == `CH_LF)
		else $error("ascii reply not ended by CR LF");

	c_rtu_write: cover property (
		frame_ok_reg && !ascii_mode && $past(write_ok));
	c_ascii_loop: cover property (
		frame_ok_reg && ascii_mode && $past(loop_ok));
	c_bcast_write: cover property (wr_valid_reg && bcast);
	c_fifo_stall: cover property (state_reg == ST_TX && !fifo_in_ready);

endmodule : frame_check

// *** frame_defs.svh ***
`ifndef FRAME_DEFS_SVH
`define FRAME_DEFS_SVH

// framing characters
`define CH_COLON      8'h3A
`define CH_CR         8'h0D
`define CH_LF         8'h0A
`define CH_DIG_LO     8'h30
`define CH_DIG_HI     8'h39
`define CH_UP_LO      8'h41
`define CH_UP_HI      8'h46
`define CH_DIG_OFS    8'h30
`define CH_UP_OFS     8'h37
`define NIB_UP_ADJ    4'h9
`define NIB_DIG_MAX   4'h9

// check values
`define CRC_PRESET    16'hFFFF
`define CRC_POLY      16'hA001
`define CRC_STEPS     4'h8
`define LRC_CLEAR     8'h00
`define LRC_ONE       8'h01

// function codes and station
`define FN_LOOP       8'h08
`define FN_WRITE      8'h10
`define BCAST_ADDR    8'h00

// stored frame layout, byte indices
`define IDX_ADDR      5'h00
`define IDX_FUNC      5'h01
`define IDX_START_HI  5'h02
`define IDX_START_LO  5'h03
`define IDX_WC_HI     5'h04
`define IDX_WC_LO     5'h05
`define IDX_BC        5'h06
`define IDX_DATA      5'h07
`define MEM_LAST      5'h1F
`define MEM_WORDS     32
`define HDR_LEN8      8'h07
`define LOOP_LEN8     8'h06
`define MAX_WORDS     8'h0C
`define ASC_CHK_LEN   8'h01
`define RTU_CHK_LEN   8'h02
`define ASC_MIN       5'h03
`define RTU_MIN       5'h04

// reply item positions
`define ASC_LRC_HI    5'h0D
`define ASC_CR        5'h0F
`define ASC_LAST      5'h10
`define ASC_BODY_LAST 5'h0C
`define RTU_CRC_LO    5'h06
`define RTU_LAST      5'h07

// timing
`define GAP_MS        10
`define CLK_KHZ       250000
`define FIFO_DEPTH    32

`endif

// *** frame_pkg.sv ***
package frame_pkg;

	typedef enum logic [1:0]
	{
		ST_RX    = 2'b00,
		ST_WRITE = 2'b01,
		ST_TX    = 2'b10
	} state_type;

endpackage : frame_pkg

// *** serial_master.sv ***
module serial_master
	(
		// clock and reset
		input  wire logic       clk,
		input  wire logic       rstn,
		// request characters toward the drive
		output logic [7:0]      rx_data,
		output logic            rx_valid,
		input  wire logic       rx_ready,
		// reply characters from the drive
		input  wire logic [7:0] tx_data,
		input  wire logic       tx_valid,
		output logic            tx_ready
	);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] send_q[$];
	logic [7:0] got_q[$];
	logic       took;
	logic       stall;
	int         seed;

	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
		took = 1'b0;
		stall = 1'b0;
		seed = 36;
	end

	always @(posedge clk)
	begin
		took <= rx_valid & rx_ready;
		if (tx_valid === 1'b1 && tx_ready)
			got_q.push_back(tx_data);
	end

	// request held until the edge that takes it
	always @(negedge clk)
	begin
		if (took)
			void'(send_q.pop_front());
		if (!rstn || send_q.size() == 0)
		begin
			rx_valid <= 1'b0;
			// idle line toggles instead of holding the last byte
			rx_data  <= ~rx_data;
		end
		else
		begin
			rx_valid <= 1'b1;
			rx_data  <= send_q[0];
		end
		tx_ready <= !stall && ($random(seed) % 4 != 0);
	end
endmodule : serial_master

// *** testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// short gap keeps frame ends quick
	localparam int GAP = 50;
	typedef logic [7:0] byte_q_type[$];

	logic        clk;
	logic        rstn;
	logic        ascii_mode;
	logic [7:0]  station_addr;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic        rx_ready;
	logic [7:0]  tx_data;
	logic        tx_valid;
	logic        tx_ready;
	logic        wr_valid;
	logic [15:0] wr_addr;
	logic [15:0] wr_data;
	logic        frame_ok;
	logic        frame_err;
	logic [31:0] wr_q[$];
	int          err_count = 0;
	int          cmp_count = 0;
	int          seed = 36;
	int          cycles = 0;
	int          ok_n = 0;
	int          bad_n = 0;
	int          last_take = -100;

	frame_check #(.GAP_CYCLES(GAP)) dut_u (.clk(clk), .rstn(rstn),
		.ascii_mode(ascii_mode), .station_addr(station_addr),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
		.frame_ok(frame_ok), .frame_err(frame_err));

	serial_master partner_u (.clk(clk), .rstn(rstn), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic wrap_up();
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	always @(posedge clk)
	begin
		cycles++;
		if (wr_valid === 1'b1)
			wr_q.push_back({wr_addr, wr_data});
		if (frame_ok === 1'b1)
			ok_n++;
		if (frame_err === 1'b1)
			bad_n++;
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
		begin
			if (!ascii_mode)
				cmp_val("rtu take spacing", 1, cycles - last_take >= 9);
			last_take = cycles;
		end
		if (cycles > 40000)
		begin
			err_count++;
			wrap_up();
		end
	end

	task automatic cmp_val(string what, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_val

	task automatic cmp_chr(string what, logic [7:0] exp, logic [7:0] got);
		cmp_val(what, {24'h000000, exp}, {24'h000000, got});
	endtask : cmp_chr

	function automatic logic [15:0] crc16(byte_q_type b);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i])
		begin
			c = c ^ {8'h00, b[i]};
			repeat (8)
				c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction : crc16

	function automatic logic [7:0] hexc(logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction : hexc

	function automatic byte_q_type framed(bit asc, byte_q_type b);
		byte_q_type  w;
		logic [7:0]  s;
		logic [15:0] c;
		s = 8'h00;
		c = crc16(b);
		if (asc)
			w.push_back(8'h3A);
		foreach (b[i])
		begin
			s = s + b[i];
			if (asc)
				w = {w, hexc(b[i][7:4]), hexc(b[i][3:0])};
			else
				w.push_back(b[i]);
		end
		s = -s;
		if (asc)
			w = {w, hexc(s[7:4]), hexc(s[3:0]), 8'h0D, 8'h0A};
		else
			w = {w, c[7:0], c[15:8]};
		return w;
	endfunction : framed

	task automatic run(bit asc, byte_q_type b, bit corrupt);
		byte_q_type  w;
		byte_q_type  r;
		logic [15:0] start;
		int          ok0;
		int          bad0;
		int          good;
		int          n;
		bit          hit;
		w = framed(asc, b);
		// flips a check character or the last data byte
		if (corrupt)
			w[w.size()-3] = w[w.size()-3] ^ 8'h01;
		good = !corrupt;
		hit = b[0] == 8'h00 || b[0] == station_addr;
		ok0 = ok_n;
		bad0 = bad_n;
		wr_q.delete();
		partner_u.got_q.delete();
		ascii_mode = asc;
		partner_u.send_q = w;
		for (n = 0; n < 3000 && ok_n + bad_n == ok0 + bad0; n++)
			@(negedge clk);
		cmp_val("frame_ok", ok0 + (good && hit), ok_n);
		cmp_val("frame_err", bad0 + !good, bad_n);
		r = {};
		if (good && hit && b[0] != 8'h00)
			r = framed(asc, b[0:5]);
		for (n = 0; n < 1000 && partner_u.got_q.size() < r.size(); n++)
			@(negedge clk);
		// lets stray replies or writes show up
		repeat (100) @(negedge clk);
		cmp_val("reply length", r.size(), partner_u.got_q.size());
		foreach (r[i])
			if (i < partner_u.got_q.size())
				cmp_chr("reply char", r[i], partner_u.got_q[i]);
		start = {b[2], b[3]};
		n = (good && hit && b[1] == 8'h10) ? b[5] : 0;
		cmp_val("write count", n, wr_q.size());
		for (int i = 0; i < n && i < wr_q.size(); i++)
			cmp_val("write", {16'(start + i), b[7+2*i], b[8+2*i]}, wr_q[i]);
	endtask : run

	initial
	begin
		byte_q_type b;
		int         wc;
		rstn = 1'b0;
		ascii_mode = 1'b0;
		station_addr = 8'h01;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		b = {8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02, 8'h04,
			8'h13, 8'h88, 8'h0F, 8'hA0};
		run(1'b0, b, 1'b0);
		run(1'b1, b, 1'b0);
		run(1'b0, b, 1'b1);
		b[0] = 8'h00;
		run(1'b0, b, 1'b0);
		b = {8'h01, 8'h08, 8'h00, 8'h00, 8'h17, 8'h70};
		partner_u.stall = 1'b1;
		fork
			begin
				repeat (300) @(negedge clk);
				partner_u.stall = 1'b0;
			end
		join_none
		run(1'b1, b, 1'b0);
		run(1'b0, b, 1'b0);
		run(1'b1, b, 1'b1);
		for (int k = 0; k < 6; k++)
		begin
			station_addr = 8'h01 + 8'($unsigned($random(seed)) % 254);
			wc = 1 + $unsigned($random(seed)) % 11;
			b = {station_addr, 8'h10, 8'($random(seed)), 8'($random(seed)),
				8'h00, 8'(wc), 8'(2 * wc)};
			repeat (2 * wc) b.push_back(8'($random(seed)));
			run(k[0], b, 1'b0);
		end
		// another station's frame must leave no trace
		station_addr = ~b[0];
		run(1'b1, b, 1'b0);
		wrap_up();
	end
endmodule : testbench
